//--- logic/tgl_loader.sv
// Our own choices: the address map and the APB slave port.
`timescale 1ns/100ps
// Contract
// - general setup shares one value set; dual channel swaps only differing fields
// - line length 1120 or 560; line valid from 9 to 1119 or 559
// - line valid quadrature start phase written as zero always
// - clamp one spans 4..14; clamp two 6..1054 or 6..527
// - both dummy-pixel clamp windows start and end at zero
// - blanking starts at 1119 or 559 and ends at 1, wrapping
// - enables one for gate, horiz one-four, samples, data, pixel; five, six zero
// - every high-drive option written zero, normal drive strength
// - delay-locked-loop range field written as 8
// - low-power bit always written zero
// - mode bit zero is program, one is execution
// - shutter setup 30, width 150, hold 20 clocks
// - generator fires shutter on line register match or forced frame entry
// - shutter pulse sits before the vertical clocking interval
// - after reset, front end loads first, then timing generator
// - shutter line beyond frame length gives no pulse; board counter times
module tgl_loader
(
  // clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [tgl_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  // board mode switch
  input  wire logic                        dual_mode_sw,
  // three-wire serial port
  output logic                             ser_clk,
  output logic                             ser_data,
  output logic                             ser_load_n,
  // load status
  output logic                             init_done
);

  tgl_pkg::tgl_state_t st_q, st_d;
  logic [3:0]                    step_q, step_d;
  logic                          dual_q, dual_d;
  logic                          done_q, done_d;
  logic                          exec_q, exec_d;

  // shifter handshake and reload pulse
  logic                          tx_start;
  logic                          tx_busy;
  logic                          tx_done;
  logic                          reload;

  // frame assembly
  logic [tgl_pkg::FRAME_W-1:0]   frame;
  logic [tgl_pkg::LEN_W-1:0]     frame_len;
  logic [tgl_pkg::SETUP_W-1:0]   setup_word;
  logic [tgl_pkg::SHUTTER_W-1:0] shutter_word;
  logic [13:0]                   enables;
  logic [9:0]                    afe_val;
  logic [2:0]                    afe_dev;
  logic [2:0]                    afe_addr;
  logic [31:0]                   status_word;

  // ***************************************************************
  // general setup word, highest field first
  // ***************************************************************
  always_comb
  begin
    enables = {tgl_pkg::EN_SAMPLE_THREE,
               tgl_pkg::EN_SAMPLE_ONE,
               tgl_pkg::EN_HORIZ_TWO,
               tgl_pkg::EN_HORIZ_ONE,
               tgl_pkg::EN_HORIZ_THREE,
               tgl_pkg::EN_PIXEL_RATE,
               tgl_pkg::EN_GRAB_CLOCK,
               tgl_pkg::EN_CONV_CLOCK,
               tgl_pkg::EN_SAMPLE_FOUR,
               tgl_pkg::EN_SAMPLE_TWO,
               tgl_pkg::EN_HORIZ_FIVE,
               tgl_pkg::EN_HORIZ_FOUR,
               tgl_pkg::EN_HORIZ_SIX,
               tgl_pkg::EN_RESET_GATE};
    // only the differing fields follow the latched mode
    setup_word = {tgl_pkg::DLL_RANGE,
                  tgl_pkg::HIGH_DRIVE_ALL,
                  enables,
                  tgl_pkg::BLANK_END,
                  dual_q ? tgl_pkg::BLANK_START_DUAL : tgl_pkg::BLANK_START_SGL,
                  tgl_pkg::DM_EDGE,
                  tgl_pkg::DM_EDGE,
                  tgl_pkg::DM_EDGE,
                  tgl_pkg::DM_EDGE,
                  dual_q ? tgl_pkg::OB2_END_DUAL : tgl_pkg::OB2_END_SGL,
                  tgl_pkg::OB2_START,
                  tgl_pkg::OB1_END,
                  tgl_pkg::OB1_START,
                  dual_q ? tgl_pkg::LV_END_DUAL : tgl_pkg::LV_END_SGL,
                  tgl_pkg::LV_QUAD_START,
                  tgl_pkg::LV_START,
                  dual_q ? tgl_pkg::PIX_PER_LINE_DUAL : tgl_pkg::PIX_PER_LINE_SGL};
    // shutter line register is not loaded here; the generator keeps the trigger
    // line match or forced frame entry fires the pulse
    // pulse always ahead of vertical clocking
    // out-of-range line: no pulse, board counter times exposure
    shutter_word = {tgl_pkg::SHUT_HOLD,
                    tgl_pkg::SHUT_WIDTH,
                    tgl_pkg::SHUT_SETUP};
  end

  // ***************************************************************
  // frame selection per load step
  // ***************************************************************
  always_comb
  begin
    // steps 0 to 3 feed front end one, 4 to 7 front end two
    afe_dev  = (step_q[2] == 1'b0) ? tgl_pkg::DEV_AFE_ONE : tgl_pkg::DEV_AFE_TWO;
    afe_addr = {1'b0, step_q[1:0]};

    case (step_q[1:0])
      2'h0:    afe_val = tgl_pkg::AFE_VAL_OPER;
      2'h1:    afe_val = tgl_pkg::AFE_VAL_CTRL;
      2'h2:    afe_val = tgl_pkg::AFE_VAL_CLMP;
      default: afe_val = tgl_pkg::AFE_VAL_GAIN;
    endcase

    frame     = '0;
    frame_len = '0;
    // device select goes out msb first, address and data lsb first
    case (step_q)
      tgl_pkg::STEP_PROGRAM:
      begin
        frame[tgl_pkg::HDR_W+tgl_pkg::CONTROL_W-1:0] =
          {tgl_pkg::MODE_PROGRAM,
           tgl_pkg::LOW_POWER_OFF,
           tgl_pkg::TG_REG_CONTROL,
           tgl_pkg::RW_WRITE,
           tgl_pkg::DEV_TIMING[0],
           tgl_pkg::DEV_TIMING[1],
           tgl_pkg::DEV_TIMING[2]};
        frame_len = 9'(tgl_pkg::HDR_W + tgl_pkg::CONTROL_W);
      end

      tgl_pkg::STEP_SETUP:
      begin
        frame[tgl_pkg::HDR_W+tgl_pkg::SETUP_W-1:0] =
          {setup_word,
           tgl_pkg::TG_REG_SETUP,
           tgl_pkg::RW_WRITE,
           tgl_pkg::DEV_TIMING[0],
           tgl_pkg::DEV_TIMING[1],
           tgl_pkg::DEV_TIMING[2]};
        frame_len = 9'(tgl_pkg::HDR_W + tgl_pkg::SETUP_W);
      end

      tgl_pkg::STEP_SHUTTER:
      begin
        frame[tgl_pkg::HDR_W+tgl_pkg::SHUTTER_W-1:0] =
          {shutter_word,
           tgl_pkg::TG_REG_SHUTTER,
           tgl_pkg::RW_WRITE,
           tgl_pkg::DEV_TIMING[0],
           tgl_pkg::DEV_TIMING[1],
           tgl_pkg::DEV_TIMING[2]};
        frame_len = 9'(tgl_pkg::HDR_W + tgl_pkg::SHUTTER_W);
      end

      tgl_pkg::STEP_EXECUTE:
      begin
        frame[tgl_pkg::HDR_W+tgl_pkg::CONTROL_W-1:0] =
          {tgl_pkg::MODE_EXECUTE,
           tgl_pkg::LOW_POWER_OFF,
           tgl_pkg::TG_REG_CONTROL,
           tgl_pkg::RW_WRITE,
           tgl_pkg::DEV_TIMING[0],
           tgl_pkg::DEV_TIMING[1],
           tgl_pkg::DEV_TIMING[2]};
        frame_len = 9'(tgl_pkg::HDR_W + tgl_pkg::CONTROL_W);
      end

      default:
      begin
        frame[tgl_pkg::HDR_W+tgl_pkg::AFE_DATA_W-1:0] =
          {afe_val,
           tgl_pkg::AFE_TEST_BIT,
           afe_addr,
           tgl_pkg::RW_WRITE,
           afe_dev[0],
           afe_dev[1],
           afe_dev[2]};
        frame_len = 9'(tgl_pkg::HDR_W + tgl_pkg::AFE_DATA_W);
      end
    endcase
  end

  // ***************************************************************
  // load sequencer
  // ***************************************************************
  always_comb
  begin
    st_d     = st_q;
    step_d   = step_q;
    dual_d   = dual_q;
    done_d   = done_q;
    exec_d   = exec_q;
    tx_start = 1'b0;

    case (st_q)
      tgl_pkg::ST_LATCH:
      begin
        // switch caught by a clocked step after release, never by reset
        dual_d = dual_mode_sw;
        step_d = 4'h0;
        exec_d = 1'b0;
        st_d   = tgl_pkg::ST_ISSUE;
      end

      tgl_pkg::ST_ISSUE:
      begin
        // one frame at a time: start only once the shifter is idle
        tx_start = !tx_busy;
        if (!tx_busy)
        begin
          st_d = tgl_pkg::ST_WAIT;
        end
      end

      tgl_pkg::ST_WAIT:
      begin
        if (tx_done)
        begin
          if (step_q == tgl_pkg::STEP_EXECUTE)
          begin
            exec_d = 1'b1;
            st_d   = tgl_pkg::ST_DONE;
          end
          else
          begin
            // advance only on done, after the last bit has gone out
            step_d = step_q + 4'h1;
            st_d   = tgl_pkg::ST_ISSUE;
          end
        end
      end

      tgl_pkg::ST_DONE:
      begin
        // done and idle status appear on the same edge
        done_d = 1'b1;
        st_d   = tgl_pkg::ST_IDLE;
      end

      tgl_pkg::ST_IDLE:
      begin
        if (reload)
        begin
          // reload ignored mid-sequence; done only drops when a new load starts
          done_d = 1'b0;
          st_d   = tgl_pkg::ST_LATCH;
        end
      end

      default:
      begin
        st_d = tgl_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // any reset restarts the load from the front end
      st_q   <= tgl_pkg::ST_LATCH;
      step_q <= 4'h0;
      dual_q <= 1'b0;
      done_q <= 1'b0;
      exec_q <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      step_q <= step_d;
      dual_q <= dual_d;
      done_q <= done_d;
      exec_q <= exec_d;
    end
  end

  // ***************************************************************
  // status word
  // ***************************************************************
  always_comb
  begin
    // busy from latch until done is set
    status_word                                   = 32'h0000_0000;
    status_word[tgl_pkg::STAT_BUSY]               = (st_q != tgl_pkg::ST_IDLE);
    status_word[tgl_pkg::STAT_DONE]               = done_q;
    status_word[tgl_pkg::STAT_DUAL]               = dual_q;
    status_word[tgl_pkg::STAT_EXEC]               = exec_q;
    status_word[tgl_pkg::STAT_STEP+3:tgl_pkg::STAT_STEP] = step_q;
  end

  assign init_done = done_q;

  // ***************************************************************
  // register slave and serial shifter
  // ***************************************************************
  tgl_apb_regs u_regs
  (
    .pclk        (pclk),
    .presetn     (presetn),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .status_word (status_word),
    .reload      (reload)
  );

  tgl_serial_tx u_tx
  (
    .pclk       (pclk),
    .presetn    (presetn),
    .start      (tx_start),
    .frame      (frame),
    .frame_len  (frame_len),
    .busy       (tx_busy),
    .done       (tx_done),
    .ser_clk    (ser_clk),
    .ser_data   (ser_data),
    .ser_load_n (ser_load_n)
  );

endmodule

//--- logic/tgl_pkg.sv
package tgl_pkg;

  // ***************************************************************
  // clock and serial framing
  // ***************************************************************
  localparam int unsigned CLK_MHZ      = 25;
  localparam int unsigned FRAME_W      = 256;
  localparam int unsigned LEN_W        = 9;
  localparam int unsigned HDR_W        = 8;
  localparam logic [2:0]  DEV_AFE_ONE  = 3'h1;
  localparam logic [2:0]  DEV_AFE_TWO  = 3'h2;
  localparam logic [2:0]  DEV_TIMING   = 3'h3;
  localparam logic        RW_WRITE     = 1'h0;
  localparam logic        AFE_TEST_BIT = 1'h0;

  // ***************************************************************
  // front-end defaults, loaded before the timing generator
  // ***************************************************************
  localparam int unsigned AFE_DATA_W   = 10;
  localparam int unsigned AFE_REGS     = 4;
  localparam logic [9:0]  AFE_VAL_OPER = 10'h000;
  localparam logic [9:0]  AFE_VAL_CTRL = 10'h000;
  localparam logic [9:0]  AFE_VAL_CLMP = 10'h060;
  localparam logic [9:0]  AFE_VAL_GAIN = 10'h014;

  // ***************************************************************
  // timing generator register addresses and widths
  // ***************************************************************
  localparam logic [3:0]  TG_REG_SETUP    = 4'h1;
  localparam logic [3:0]  TG_REG_CONTROL  = 4'h2;
  localparam logic [3:0]  TG_REG_SHUTTER  = 4'h3;
  localparam int unsigned SETUP_W         = 202;
  localparam int unsigned CONTROL_W       = 2;
  localparam int unsigned SHUTTER_W       = 30;
  localparam int unsigned PIX_W           = 13;

  // ***************************************************************
  // general setup values, single/binning and dual channel
  // ***************************************************************
  localparam logic [12:0] PIX_PER_LINE_SGL = 13'h0460;
  localparam logic [12:0] PIX_PER_LINE_DUAL = 13'h0230;
  localparam logic [12:0] LV_START          = 13'h0009;
  localparam logic [1:0]  LV_QUAD_START     = 2'h0;
  localparam logic [12:0] LV_END_SGL        = 13'h045F;
  localparam logic [12:0] LV_END_DUAL       = 13'h022F;
  localparam logic [12:0] OB1_START         = 13'h0004;
  localparam logic [12:0] OB1_END           = 13'h000E;
  localparam logic [12:0] OB2_START         = 13'h0006;
  localparam logic [12:0] OB2_END_SGL       = 13'h041E;
  localparam logic [12:0] OB2_END_DUAL      = 13'h020F;
  localparam logic [12:0] DM_EDGE           = 13'h0000;
  localparam logic [12:0] BLANK_START_SGL   = 13'h045F;
  localparam logic [12:0] BLANK_START_DUAL  = 13'h022F;
  localparam logic [12:0] BLANK_END         = 13'h0001;

  // output enables, one bit per clock, lowest bit first
  localparam logic EN_RESET_GATE   = 1'h1;
  localparam logic EN_HORIZ_SIX    = 1'h0;
  localparam logic EN_HORIZ_FOUR   = 1'h1;
  localparam logic EN_HORIZ_FIVE   = 1'h0;
  localparam logic EN_SAMPLE_TWO   = 1'h1;
  localparam logic EN_SAMPLE_FOUR  = 1'h1;
  localparam logic EN_CONV_CLOCK   = 1'h1;
  localparam logic EN_GRAB_CLOCK   = 1'h1;
  localparam logic EN_PIXEL_RATE   = 1'h1;
  localparam logic EN_HORIZ_THREE  = 1'h1;
  localparam logic EN_HORIZ_ONE    = 1'h1;
  localparam logic EN_HORIZ_TWO    = 1'h1;
  localparam logic EN_SAMPLE_ONE   = 1'h1;
  localparam logic EN_SAMPLE_THREE = 1'h1;
  localparam logic [12:0] HIGH_DRIVE_ALL = 13'h0000;
  localparam logic [3:0]  DLL_RANGE      = 4'h8;

  // ***************************************************************
  // general control and shutter
  // ***************************************************************
  localparam logic        LOW_POWER_OFF = 1'h0;
  localparam logic        MODE_PROGRAM  = 1'h0;
  localparam logic        MODE_EXECUTE  = 1'h1;
  localparam logic [9:0]  SHUT_SETUP    = 10'h01E;
  localparam logic [9:0]  SHUT_WIDTH    = 10'h096;
  localparam logic [9:0]  SHUT_HOLD     = 10'h014;

  // ***************************************************************
  // load sequence
  // ***************************************************************
  localparam logic [3:0] STEP_AFE_LAST = 4'h7;
  localparam logic [3:0] STEP_PROGRAM  = 4'h8;
  localparam logic [3:0] STEP_SETUP    = 4'h9;
  localparam logic [3:0] STEP_SHUTTER  = 4'hA;
  localparam logic [3:0] STEP_EXECUTE  = 4'hB;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b000,
    ST_LATCH = 3'b001,
    ST_ISSUE = 3'b010,
    ST_WAIT  = 3'b011,
    ST_DONE  = 3'b100
  } tgl_state_t;

  // ***************************************************************
  // apb register map
  // ***************************************************************
  localparam int unsigned ADDR_W      = 12;
  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_STATUS  = 12'h004;
  localparam logic [11:0] OFS_VERSION = 12'h008;
  localparam int unsigned CTRL_RELOAD = 0;
  localparam int unsigned STAT_BUSY   = 0;
  localparam int unsigned STAT_DONE   = 1;
  localparam int unsigned STAT_DUAL   = 2;
  localparam int unsigned STAT_EXEC   = 3;
  localparam int unsigned STAT_STEP   = 4;
  // arbitrary value
  localparam logic [31:0] VERSION_VAL = 32'h0000_0101;

endpackage

//--- logic/tgl_serial_tx.sv
`timescale 1ns/100ps
module tgl_serial_tx
(
  // clock and reset
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  // frame request
  input  wire logic                            start,
  input  wire logic [tgl_pkg::FRAME_W-1:0]     frame,
  input  wire logic [tgl_pkg::LEN_W-1:0]       frame_len,
  output logic                                 busy,
  output logic                                 done,
  // three-wire serial port
  output logic                                 ser_clk,
  output logic                                 ser_data,
  output logic                                 ser_load_n
);

  logic [tgl_pkg::FRAME_W-1:0] sh_q, sh_d;
  logic [tgl_pkg::LEN_W-1:0]   cnt_q, cnt_d;
  logic                        act_q, act_d;
  logic                        ph_q, ph_d;
  logic                        clk_q, clk_d;
  logic                        dat_q, dat_d;
  logic                        ld_q, ld_d;
  logic                        done_q, done_d;

  // ***************************************************************
  // shifter: bit 0 first, data changes while the serial clock is low
  // ***************************************************************
  always_comb
  begin
    sh_d   = sh_q;
    cnt_d  = cnt_q;
    act_d  = act_q;
    ph_d   = ph_q;
    clk_d  = clk_q;
    dat_d  = dat_q;
    ld_d   = ld_q;
    done_d = 1'b0;
    if (!act_q && start)
    begin
      sh_d  = frame;
      cnt_d = frame_len - 9'h001;
      act_d = 1'b1;
      ph_d  = 1'b0;
      clk_d = 1'b0;
      dat_d = frame[0];
      ld_d  = 1'b0;
    end
    else if (act_q && !ph_q)
    begin
      clk_d = 1'b1;
      ph_d  = 1'b1;
    end
    else if (act_q)
    begin
      clk_d = 1'b0;
      ph_d  = 1'b0;
      if (cnt_q == '0)
      begin
        // load rises only after the last bit is clocked: one write per frame
        act_d  = 1'b0;
        ld_d   = 1'b1;
        dat_d  = 1'b0;
        done_d = 1'b1;
      end
      else
      begin
        sh_d  = sh_q >> 1;
        dat_d = sh_q[1];
        cnt_d = cnt_q - 9'h001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sh_q   <= '0;
      cnt_q  <= '0;
      act_q  <= 1'b0;
      ph_q   <= 1'b0;
      clk_q  <= 1'b0;
      dat_q  <= 1'b0;
      ld_q   <= 1'b1;
      done_q <= 1'b0;
    end
    else
    begin
      sh_q   <= sh_d;
      cnt_q  <= cnt_d;
      act_q  <= act_d;
      ph_q   <= ph_d;
      clk_q  <= clk_d;
      dat_q  <= dat_d;
      ld_q   <= ld_d;
      done_q <= done_d;
    end
  end

  assign busy       = act_q;
  assign done       = done_q;
  assign ser_clk    = clk_q;
  assign ser_data   = dat_q;
  assign ser_load_n = ld_q;

endmodule

//--- logic/tgl_apb_regs.sv
`timescale 1ns/100ps
module tgl_apb_regs
(
  // clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [tgl_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  // loader side
  input  wire logic [31:0]                 status_word,
  output logic                             reload
);

  logic        rdy_q, rdy_d;
  logic        err_q, err_d;
  logic [31:0] rd_q, rd_d;
  logic        rl_q, rl_d;
  logic        hit;

  // ***************************************************************
  // one wait state; the write lands on the edge that sees pready
  // ***************************************************************
  always_comb
  begin
    hit  = (paddr == tgl_pkg::OFS_CTRL) || (paddr == tgl_pkg::OFS_STATUS) ||
           (paddr == tgl_pkg::OFS_VERSION);
    rdy_d = psel && penable && !rdy_q;
    err_d = rdy_d && !hit;
    rd_d  = 32'h0000_0000;
    if (rdy_d && !pwrite)
    begin
      case (paddr)
        tgl_pkg::OFS_STATUS:  rd_d = status_word;
        tgl_pkg::OFS_VERSION: rd_d = tgl_pkg::VERSION_VAL;
        default:              rd_d = 32'h0000_0000;
      endcase
    end
    rl_d = psel && penable && rdy_q && pwrite && (paddr == tgl_pkg::OFS_CTRL) &&
           pwdata[tgl_pkg::CTRL_RELOAD];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdy_q <= 1'b0;
      err_q <= 1'b0;
      rd_q  <= 32'h0000_0000;
      rl_q  <= 1'b0;
    end
    else
    begin
      rdy_q <= rdy_d;
      err_q <= err_d;
      rd_q  <= rd_d;
      rl_q  <= rl_d;
    end
  end

  assign pready  = rdy_q;
  assign pslverr = err_q;
  assign prdata  = rd_q;
  assign reload  = rl_q;

endmodule

//--- tb/tgl_loader_asserts.sv
`timescale 1ns/100ps
module tgl_loader_asserts
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // serial port and status
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_load_n,
  input wire logic init_done
);
  // *****
  // serial framing
  // *****
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_CLK_IDLE: assert property
    (ser_load_n |-> !ser_clk) else $error("serial clock moves outside a frame");
  AST_LOAD_GAP: assert property
    ($rose(ser_load_n) |=> ser_load_n) else $error("frame gap too short");
  AST_FRAME_START: assert property
    ($fell(ser_load_n) |-> !ser_clk ##1 ser_clk) else $error("frame starts badly");
  AST_DATA_HOLD: assert property
    (!ser_load_n && ser_clk |-> $stable(ser_data)) else $error("data moves with clock high");
  AST_CLK_TOGGLE: assert property
    (!ser_load_n && !$past(ser_load_n) |-> ser_clk != $past(ser_clk)) else $error("clock stalls");
  AST_DATA_IDLE: assert property
    ($rose(ser_load_n) |-> !ser_data) else $error("data not low after frame");
  AST_DONE_IDLE: assert property
    (init_done |-> ser_load_n) else $error("frame while done");
  AST_DONE_RISE: assert property
    ($rose(init_done) |-> $past(ser_load_n)) else $error("done before last frame ended");
endmodule
bind tgl_loader tgl_loader_asserts u_tgl_loader_asserts (.pclk, .presetn, .ser_clk, .ser_data, .ser_load_n, .init_done);

//--- tb/tgl_rx_model.sv
`timescale 1ns/100ps
module tgl_rx_model
(
  // serial port
  input wire logic      ser_clk,
  input wire logic      ser_data,
  input wire logic      ser_load_n,
  // bench control
  input wire logic      clr,
  // captured frames
  output logic [255:0]  frm [0:15],
  output int            len [0:15],
  output int            nf,
  output int            bad
);
  logic [255:0] sh;
  int           n;
  logic         exec;
  initial
  begin
    nf = 0; bad = 0; exec = 1; n = 0;
  end
  always @(posedge clr)
  begin
    nf = 0; bad = 0; exec = 1;
  end
  always @(negedge ser_load_n)
  begin
    sh = '0; n = 0;
  end
  always @(posedge ser_clk)
    if (!ser_load_n && n < 256)
    begin
      sh[n] = ser_data; n++;
    end
  // registers only take writes in program mode
  always @(posedge ser_load_n)
    if (!clr && n > 0 && nf < 16)
    begin
      frm[nf] = sh; len[nf] = n; nf++;
      if (sh[2:0] == 3'h6 && sh[7:4] == 4'h2 && n == 10) exec = sh[9];
      else if (sh[2:0] == 3'h6 && exec) bad++;
    end
endmodule

//--- tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  typedef struct packed {logic [2:0] dev; logic [3:0] adr; int w; logic [201:0] dat;} tgl_row_t;
  logic pclk, presetn, psel, penable, pwrite, dual_mode_sw, clr, pready, pslverr, e;
  logic ser_clk, ser_data, ser_load_n, init_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [255:0] frm [0:15];
  int len [0:15];
  int nf, bad, n_mismatch, check_count;
  tgl_row_t rows [0:11];
  tgl_loader u_tgl_loader (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .dual_mode_sw, .ser_clk, .ser_data, .ser_load_n, .init_done);
  tgl_rx_model u_tgl_rx_model (.ser_clk, .ser_data, .ser_load_n, .clr, .frm, .len, .nf, .bad);
  initial
  begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  task automatic chk(input logic [255:0] g, input logic [255:0] x, input string m);
    check_count++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic final_report;
    if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 20);
    rd = prdata; e = pslverr; psel <= 0; penable <= 0;
    if (i >= 20) begin chk(0, 1, "apb timeout"); final_report(); end
  endtask
  task automatic wait_done(input logic lvl);
    int i;
    for (i = 0; i < 20000 && init_done !== lvl; i++) @(posedge pclk);
    if (i >= 20000) begin chk(0, 1, "load timeout"); final_report(); end
  endtask
  // one row per serial write, in load order
  task automatic check_load(input logic d);
    logic [12:0] p, le, o2;
    p = d ? 13'h0230 : 13'h0460;
    le = d ? 13'h022F : 13'h045F;
    o2 = d ? 13'h020F : 13'h041E;
    for (int i = 0; i < 8; i++)
      rows[i] = '{(i < 4) ? 3'h1 : 3'h2, 4'(i % 4), 10, (i % 4 == 2) ? 10'h060 : (i % 4 == 3) ? 10'h014 : 10'h000};
    rows[8] = '{3'h3, 4'h2, 2, 202'h0};
    rows[9] = '{3'h3, 4'h1, 202, {4'h8, 13'h0000, 14'h3FF5, 13'h0001, le, 52'h0, o2, 13'h0006, 13'h000E,
      13'h0004, le, 2'h0, 13'h0009, p}};
    rows[10] = '{3'h3, 4'h3, 30, {10'h014, 10'h096, 10'h01E}};
    rows[11] = '{3'h3, 4'h2, 2, 202'h2};
    chk(nf, 12, "frame count");
    chk(bad, 0, "write outside program mode");
    for (int i = 0; i < 12; i++)
    begin
      chk(len[i], 8 + rows[i].w, "frame length");
      chk(frm[i], {rows[i].dat, rows[i].adr, 1'b0, rows[i].dev[0], rows[i].dev[1], rows[i].dev[2]},
        "frame content");
    end
  endtask
  initial
  begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; dual_mode_sw = 0; clr = 1;
    repeat (2) @(posedge pclk);
    presetn <= 1; clr <= 0;
    wait_done(1);
    check_load(0);
    apb(0, 12'h004, 32'h0);
    chk(rd[7:0], 8'hBA, "status after load");
    chk(e, 0, "status read refused");
    apb(0, 12'h008, 32'h0);
    chk(rd, tgl_pkg::VERSION_VAL, "version word");
    chk(e, 0, "version read refused");
    apb(0, 12'h00C, 32'h0);
    chk(e, 1, "unmapped read not refused");
    // switch latched at load start; reload while busy is dropped
    dual_mode_sw <= 1; clr <= 1;
    @(posedge pclk);
    clr <= 0;
    apb(1, 12'h000, 32'h1);
    wait_done(0);
    repeat (4) @(posedge pclk);
    dual_mode_sw <= 0;
    apb(1, 12'h000, 32'h1);
    wait_done(1);
    check_load(1);
    apb(0, 12'h004, 32'h0);
    chk(rd[7:0], 8'hBE, "status after dual load");
    // reset in mid-load restarts from the front end
    clr <= 1;
    apb(1, 12'h000, 32'h1);
    repeat (300) @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1; clr <= 0;
    wait_done(1);
    check_load(0);
    final_report();
  end
endmodule
